// ==== tma_pkg.sv ====
// shared constants and carrier types for the multifunction timer channel
package tma_pkg;
   // operating mode field, low two bits of the mode register
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [1:0] MODE_EVENT = 2'h1;
   // internal count source select in timer mode
   localparam logic [1:0] SRC_UNDIV = 2'h0;
   localparam logic [1:0] SRC_DIV8 = 2'h1;
   localparam logic [1:0] SRC_DIV32 = 2'h2;
   localparam logic [1:0] SRC_SUB32 = 2'h3;
   // event source select in event counter mode
   localparam logic [1:0] EVT_PIN = 2'h0;
   localparam logic [1:0] EVT_SECOND = 2'h1;
   localparam logic [1:0] EVT_FIFTH = 2'h2;
   localparam logic [1:0] EVT_PEER = 2'h3;
   // counter limits and reset values
   localparam logic [15:0] CNT_MIN = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] CNT_RST = 16'h0000;
   // prescaler taps for the divide-by-8 and divide-by-32 enables
   localparam int PRE_WIDTH = 5;
   localparam logic [4:0] PRE_DIV8_MASK = 5'h07;
   localparam logic [4:0] PRE_DIV32_MASK = 5'h1f;
   localparam logic [4:0] PRE_RST = 5'h00;
   // channels able to count two-phase signals
   localparam logic [7:0] TWO_PHASE_CHANNELS = 8'h9c;

   // configuration held by software, one struct per channel
   typedef struct packed {
      logic [1:0] mode_sel;     // operating mode
      logic count_start;        // count start flag
      logic [1:0] src_sel;      // timer mode clock source
      logic gate_enable;        // timer mode gate function on
      logic gate_level;         // gate level that permits counting
      logic pulse_enable;       // pulse output function on
      logic [1:0] event_sel;    // event counter source
      logic edge_rising;        // 1 rising, 0 falling active edge
      logic dir_from_pin;       // direction taken from the shared pin
      logic sw_count_up;        // software direction, 1 up
      logic free_run;           // no reload on overflow or underflow, event mode only
      logic port_value;         // general port output level
      logic port_drive;         // general port output enable
   } tma_cfg_t;

   // overflow pulses from other timer channels
   typedef struct packed {
      logic second_input_timer_overflow_src;
      logic fifth_input_timer_overflow_src;
      logic peer_output_timer_overflow_src;
   } tma_ovf_t;
endpackage : tma_pkg

// ==== tma_channel.sv ====
// one 16-bit timer channel: timer mode and single-phase event counter mode
`timescale 1ns/100ps
module tma_channel #(
   parameter int CHANNEL_INDEX = 0,
   parameter int CNT_WIDTH = 16
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire tma_pkg::tma_cfg_t cfg,
   input wire logic wr_strobe,
   input wire logic [CNT_WIDTH-1:0] wr_value,
   input wire logic sub_clock_div32,
   input wire tma_pkg::tma_ovf_t ovf_in,
   input wire logic timer_count_gate_input,
   input wire logic timer_output_direction_pin_in,
   output logic timer_output_direction_pin_out,
   output logic timer_output_direction_pin_oe,
   output logic [CNT_WIDTH-1:0] count_value,
   output logic irq_request,
   output logic two_phase_capable
);
   // prescaler and derived enables
   logic [tma_pkg::PRE_WIDTH-1:0] prescale;
   logic sys_clock_undivided;
   logic sys_clock_div8;
   logic sys_clock_div32;
   // counter state
   logic [CNT_WIDTH-1:0] reload;      // reload register
   logic [CNT_WIDTH-1:0] next_count;
   logic [CNT_WIDTH-1:0] next_reload;
   logic pin_prev;                    // previous count input level
   logic timer_pulse_output;          // toggling pulse level
   logic next_pulse;
   // decoded controls
   logic running;
   logic mode_timer;
   logic mode_event;
   logic src_tick;
   logic gate_ok;
   logic pin_edge;
   logic evt_tick;
   logic tick;
   logic count_up;
   logic at_limit;
   logic wrap_event;
   logic [CNT_WIDTH-1:0] wrap_value;
   logic [CNT_WIDTH-1:0] step_value;
   logic pin_is_dir;
   logic next_pin_out;
   logic next_pin_oe;

   localparam logic [CNT_WIDTH-1:0] LIM_LO = CNT_WIDTH'(tma_pkg::CNT_MIN);
   localparam logic [CNT_WIDTH-1:0] LIM_HI = CNT_WIDTH'(tma_pkg::CNT_MAX);

   // mode decode from the two-bit field
   assign mode_timer = (cfg.mode_sel == tma_pkg::MODE_TIMER);
   assign mode_event = (cfg.mode_sel == tma_pkg::MODE_EVENT);
   assign running = cfg.count_start;

   // internal clock enables on ref_clk: undivided held high, divided ones one-cycle pulses
   assign sys_clock_undivided = 1'b1;
   assign sys_clock_div8 = ((prescale & tma_pkg::PRE_DIV8_MASK) == tma_pkg::PRE_DIV8_MASK);
   assign sys_clock_div32 = (prescale == tma_pkg::PRE_DIV32_MASK);

   // timer mode source selection
   assign src_tick = (cfg.src_sel == tma_pkg::SRC_UNDIV) ? sys_clock_undivided :
                     (cfg.src_sel == tma_pkg::SRC_DIV8) ? sys_clock_div8 :
                     (cfg.src_sel == tma_pkg::SRC_DIV32) ? sys_clock_div32 :
                     sub_clock_div32;

   // gate input permits counting only at the chosen level
   assign gate_ok = !cfg.gate_enable || (timer_count_gate_input == cfg.gate_level);

   // edge on the count input, active edge chosen by software
   assign pin_edge = cfg.edge_rising ? (timer_count_gate_input && !pin_prev)
                                     : (!timer_count_gate_input && pin_prev);

   // event source selection
   assign evt_tick = (cfg.event_sel == tma_pkg::EVT_PIN) ? pin_edge :
                     (cfg.event_sel == tma_pkg::EVT_SECOND) ?
                        ovf_in.second_input_timer_overflow_src :
                     (cfg.event_sel == tma_pkg::EVT_FIFTH) ?
                        ovf_in.fifth_input_timer_overflow_src :
                     ovf_in.peer_output_timer_overflow_src;

   // one count step this cycle; unsupported modes hold the count
   assign tick = running && ((mode_timer && src_tick && gate_ok) || (mode_event && evt_tick));

   // direction: timer mode always down, event mode by pin or software
   assign pin_is_dir = mode_event && cfg.dir_from_pin && !cfg.pulse_enable;
   assign count_up = mode_event &&
                     (cfg.dir_from_pin ? timer_output_direction_pin_in : cfg.sw_count_up);

   // overflow at the top when up, underflow at zero when down
   assign at_limit = count_up ? (count_value == LIM_HI) : (count_value == LIM_LO);
   assign wrap_event = tick && at_limit;
   assign step_value = count_up ? count_value + 1'b1 : count_value - 1'b1;

   // reload on wrap unless free-run in event mode, which lets it roll over
   assign wrap_value = (mode_event && cfg.free_run) ? step_value : reload;

   // next counter and reload values, write handling
   always_comb begin
      next_reload = reload;
      next_count = count_value;
      if (tick) begin
         next_count = at_limit ? wrap_value : step_value;
      end
      if (wr_strobe) begin
         next_reload = wr_value;
         if (!running) begin
            next_count = wr_value;
         end
      end
   end

   // pulse output: low while stopped, toggles on every wrap when enabled
   assign next_pulse = !running ? 1'b0 :
                       (wrap_event && cfg.pulse_enable) ? !timer_pulse_output :
                       timer_pulse_output;

   // shared pin: direction input, pulse output, or general port
   assign next_pin_oe = pin_is_dir ? 1'b0 : (cfg.pulse_enable ? 1'b1 : cfg.port_drive);
   assign next_pin_out = cfg.pulse_enable ? next_pulse : cfg.port_value;

   // prescaler runs free so divided enables keep a steady phase
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prescale <= tma_pkg::PRE_RST;
      end else begin
         prescale <= prescale + 1'b1;
      end
   end

   // counter, reload register and the live count read port
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         count_value <= CNT_WIDTH'(tma_pkg::CNT_RST);
         reload <= CNT_WIDTH'(tma_pkg::CNT_RST);
      end else begin
         count_value <= next_count;
         reload <= next_reload;
      end
   end

   // interrupt request, one cycle per wrap in either mode
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= wrap_event;
      end
   end

   // pin state and edge history
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pin_prev <= 1'b0;
         timer_pulse_output <= 1'b0;
         timer_output_direction_pin_out <= 1'b0;
         timer_output_direction_pin_oe <= 1'b0;
      end else begin
         pin_prev <= timer_count_gate_input;
         timer_pulse_output <= next_pulse;
         timer_output_direction_pin_out <= next_pin_out;
         timer_output_direction_pin_oe <= next_pin_oe;
      end
   end

   // capability flag fixed by channel number; two-phase logic lives elsewhere
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         two_phase_capable <= 1'b0;
      end else begin
         two_phase_capable <= tma_pkg::TWO_PHASE_CHANNELS[CHANNEL_INDEX[2:0]];
      end
   end

   // checks on the counting behaviour
   property p_stop_hold;
      @(posedge ref_clk) disable iff (srst)
      (!running && !wr_strobe) |=> (count_value == $past(count_value));
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("count moved while stopped");

   property p_timer_reload;
      @(posedge ref_clk) disable iff (srst)
      (mode_timer && tick && count_value == LIM_LO && !wr_strobe)
         |=> (count_value == $past(reload)) && irq_request;
   endproperty
   a_timer_reload: assert property (p_timer_reload) else $error("no reload on underflow");

   property p_stopped_write;
      @(posedge ref_clk) disable iff (srst)
      (wr_strobe && !running) |=> (count_value == $past(wr_value)) && (reload == $past(wr_value));
   endproperty
   a_stopped_write: assert property (p_stopped_write) else $error("stopped write lost");

   property p_running_write;
      @(posedge ref_clk) disable iff (srst)
      (wr_strobe && running && !tick) |=> (count_value == $past(count_value))
         && (reload == $past(wr_value));
   endproperty
   a_running_write: assert property (p_running_write) else $error("running write hit count");

   property p_gate_block;
      @(posedge ref_clk) disable iff (srst)
      (mode_timer && cfg.gate_enable && timer_count_gate_input != cfg.gate_level && !wr_strobe)
         |=> (count_value == $past(count_value));
   endproperty
   a_gate_block: assert property (p_gate_block) else $error("counted with gate closed");

   property p_pulse_toggle;
      @(posedge ref_clk) disable iff (srst)
      (running && cfg.pulse_enable && wrap_event) ##1 running
         |-> (timer_pulse_output != $past(timer_pulse_output));
   endproperty
   a_pulse_toggle: assert property (p_pulse_toggle) else $error("pulse did not toggle");

   property p_free_run;
      @(posedge ref_clk) disable iff (srst)
      (mode_event && cfg.free_run && count_up && tick && count_value == LIM_HI && !wr_strobe)
         |=> (count_value == LIM_LO) ##0 irq_request;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free-run did not wrap");

   property p_stop_low;
      @(posedge ref_clk) disable iff (srst)
      !running |=> !timer_pulse_output;
   endproperty
   a_stop_low: assert property (p_stop_low) else $error("pulse high while stopped");

   property p_event_down_reload;
      @(posedge ref_clk) disable iff (srst)
      (mode_event && !cfg.free_run && !count_up && tick && count_value == LIM_LO && !wr_strobe)
         |=> (count_value == $past(reload)) && irq_request;
   endproperty
   a_event_down_reload: assert property (p_event_down_reload) else $error("event reload lost");

   property p_dir_pin_released;
      @(posedge ref_clk) disable iff (srst)
      pin_is_dir |=> !timer_output_direction_pin_oe;
   endproperty
   a_dir_pin_released: assert property (p_dir_pin_released) else $error("driving direction pin");
endmodule : tma_channel

// ==== tma_ext_model.sv ====
// far-side model: drives the gate/count pin and the direction level
`timescale 1ns/100ps
module tma_ext_model (
   input wire logic ref_clk,
   output logic gate_pin,
   output logic dir_level
);
   // both lines start low so the first pulse is a clean rising edge
   initial begin
      gate_pin = 1'b0;
      dir_level = 1'b0;
   end
   // static levels; changed off the sampling edge
   task automatic level(input logic g, input logic d);
      @(negedge ref_clk);
      gate_pin = g;
      dir_level = d;
   endtask : level
   // k full pulses, two cycles high and two low, so every edge is seen
   task automatic pulse(input int k);
      for (int i = 0; i < k; i++) begin
         @(negedge ref_clk);
         gate_pin = 1'b1;
         repeat (2) @(negedge ref_clk);
         gate_pin = 1'b0;
         @(negedge ref_clk);
      end
   endtask : pulse
endmodule : tma_ext_model

// ==== timer_a_timer_event_modes_tb.sv ====
// self-checking bench for the timer channel in timer and event modes
`timescale 1ns/100ps
module timer_a_timer_event_modes_tb;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   tma_pkg::tma_cfg_t cfg = '0;
   logic wr_strobe = 1'b0;
   logic [15:0] wr_value = 16'h0000;
   logic sub_clk = 1'b0;
   tma_pkg::tma_ovf_t ovf = '0;
   wire logic gate_pin, dir_lvl, pin_out, pin_oe, irq, two_ph;
   wire logic [15:0] count;
   // resolved shared pin: the channel wins while it drives
   wire logic pin_wire = pin_oe ? pin_out : dir_lvl;
   int errors = 0, checks = 0, cyc = 0, irqs = 0, gap = 0, e, n, dv;
   int seed = 32'h96de;
   int exp_q[$]; // expected gap per interrupt, 0 = gap not checked
   tma_channel #(.CHANNEL_INDEX(2), .CNT_WIDTH(16)) uut (.ref_clk(ref_clk), .srst(srst),
      .cfg(cfg), .wr_strobe(wr_strobe), .wr_value(wr_value), .sub_clock_div32(sub_clk),
      .ovf_in(ovf), .timer_count_gate_input(gate_pin), .timer_output_direction_pin_in(pin_wire),
      .timer_output_direction_pin_out(pin_out), .timer_output_direction_pin_oe(pin_oe),
      .count_value(count), .irq_request(irq), .two_phase_capable(two_ph));
   tma_ext_model ext (.ref_clk(ref_clk), .gate_pin(gate_pin), .dir_level(dir_lvl));
   always #2 ref_clk = ~ref_clk;
   // sub clock enable: one cycle in four
   always @(negedge ref_clk) sub_clk <= (cyc % 4 == 3);
   task automatic fail(input logic [31:0] g, input logic [31:0] x);
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
   endtask : fail
   task automatic check_int(input int g, input int x);
      checks++;
      if (g != x) fail(g, x);
   endtask : check_int
   task automatic check16(input logic [15:0] g, input logic [15:0] x);
      checks++;
      if (g !== x) fail(g, x);
   endtask : check16
   task automatic check_bit(input logic g, input logic x);
      checks++;
      if (g !== x) fail(g, x);
   endtask : check_bit
   task automatic print_verdict();
      if (errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   // monitor: every interrupt takes the oldest note; a spare one is a fault
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      gap <= gap + 1;
      if (cyc > 20000) begin
         errors++; // timeout counts as a mismatch
         print_verdict();
      end else if (irq === 1'b1) begin
         irqs <= irqs + 1;
         gap <= 1;
         if (exp_q.size() == 0) check_int(1, 0);
         else begin
            e = exp_q.pop_front();
            if (e != 0) check_int(gap, e);
         end
      end
   end
   task automatic wr(input logic [15:0] v);
      @(negedge ref_clk);
      wr_value = v;
      wr_strobe = 1'b1;
      @(negedge ref_clk);
      wr_strobe = 1'b0;
   endtask : wr
   // the global cycle ceiling bounds this wait
   task automatic wait_irqs(input int k);
      int t;
      t = irqs + k;
      while (irqs < t) @(negedge ref_clk);
   endtask : wait_irqs
   task automatic stop();
      cfg.count_start = 1'b0;
      repeat (2) @(negedge ref_clk);
      check_bit(pin_out, 1'b0);
   endtask : stop
   // event run: source, up, direction from pin, free-run, preset, events, irqs, end count
   task automatic ev(input logic [1:0] es, input logic up, input logic dp, input logic fr,
      input logic [15:0] v, input int k, input int ni, input logic [15:0] ec);
      cfg = '0;
      cfg.mode_sel = tma_pkg::MODE_EVENT;
      cfg.event_sel = es;
      cfg.edge_rising = up;
      cfg.sw_count_up = up ^ dp; // software disagrees when the pin sets direction
      cfg.dir_from_pin = dp;
      cfg.free_run = fr;
      cfg.pulse_enable = fr;
      wr(v);
      if (dp) ext.level(1'b0, up);
      exp_q.push_back(0);
      // later wraps come every divide ratio of events: 4 cycles per pin pulse, 2 per overflow
      dv = (es == tma_pkg::EVT_PIN) ? 4 : 2;
      repeat (ni - 1) exp_q.push_back(dv * (up ? 32'hffff - v + 1 : v + 1));
      cfg.count_start = 1'b1;
      if (es == tma_pkg::EVT_PIN) ext.pulse(k);
      else begin
         for (int i = 0; i < k; i++) begin
            @(negedge ref_clk);
            ovf = 3'h1 << (3 - es);
            @(negedge ref_clk);
            ovf = ~(3'h1 << (3 - es)); // unselected sources must not count
         end
         @(negedge ref_clk);
         ovf = '0;
      end
      repeat (4) @(negedge ref_clk);
      check_int(exp_q.size(), 0);
      check16(count, ec);
      if (fr) check_bit(pin_out, 1'b1);
      if (dp) check_bit(pin_oe, 1'b0);
      stop();
   endtask : ev
   initial begin
      repeat (3) @(negedge ref_clk);
      srst = 1'b0;
      @(negedge ref_clk);
      check16(count, tma_pkg::CNT_RST);
      check_bit(pin_oe, 1'b0);
      check_bit(two_ph, 1'b1);
      // unimplemented mode holds the count; general port drives the shared pin
      cfg.mode_sel = 2'h2;
      cfg.count_start = 1'b1;
      cfg.port_drive = 1'b1;
      cfg.port_value = 1'b1;
      repeat (4) @(negedge ref_clk);
      check16(count, tma_pkg::CNT_RST);
      check_bit(pin_oe, 1'b1);
      check_bit(pin_out, 1'b1);
      // timer mode through every clock source, three underflows each
      for (int s = 0; s < 4; s++) begin
         n = 1 + ($unsigned($random(seed)) % 5);
         dv = (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 32 : 4;
         cfg = '0;
         cfg.src_sel = s[1:0];
         cfg.pulse_enable = 1'b1;
         wr(n[15:0]);
         check16(count, n[15:0]);
         exp_q.push_back(0);
         repeat (2) exp_q.push_back(dv * (n + 1));
         cfg.count_start = 1'b1;
         wait_irqs(3);
         check_bit(pin_out, 1'b1);
         check_bit(pin_oe, 1'b1);
         stop();
      end
      // running write: next period keeps old reload, the one after uses new
      cfg = '0;
      wr(16'h0003);
      exp_q = '{0, 4, 6};
      cfg.count_start = 1'b1;
      wait_irqs(1);
      wr(16'h0005);
      wait_irqs(2);
      stop();
      // gate held closed: no count; opened: counting resumes
      cfg.gate_enable = 1'b1;
      cfg.gate_level = 1'b1;
      wr(16'h0007);
      cfg.count_start = 1'b1;
      repeat (10) @(negedge ref_clk);
      check16(count, 16'h0007);
      exp_q.push_back(0);
      ext.level(1'b1, 1'b0);
      wait_irqs(1);
      stop();
      ext.level(1'b0, 1'b0);
      // event modes: pin up, pin down by direction pin, free-run, overflow sources
      ev(tma_pkg::EVT_PIN, 1'b1, 1'b0, 1'b0, 16'hfffd, 6, 2, 16'hfffd);
      ev(tma_pkg::EVT_PIN, 1'b0, 1'b1, 1'b0, 16'h0002, 6, 2, 16'h0002);
      ev(tma_pkg::EVT_PIN, 1'b1, 1'b0, 1'b1, 16'hfffe, 3, 1, 16'h0001);
      for (int s = 1; s < 4; s++) ev(s[1:0], 1'b0, 1'b0, 1'b0, 16'h0001, 4, 2, 16'h0001);
      print_verdict();
   end
endmodule : timer_a_timer_event_modes_tb
